/* File: common/tsi_pkg.sv */
/*
  Constants for the two-wire slave interface: register offsets, field
  positions, reset values, mode codes and timing figures.
  Assumes a 100 MHz core clock and an 8-bit register port.
*/
package tsi_pkg;
  localparam int unsigned CORE_CLK_MHZ = 100;
  localparam int unsigned ADDR_W = 3;
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_CTRL = 3'h1;
  localparam logic [2:0] OFS_DATA = 3'h2;
  localparam logic [2:0] OFS_ADDR = 3'h3;
  localparam logic [2:0] OFS_TOUT = 3'h4;
  // Mode register
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned ENABLE_BIT = 1;
  localparam logic [2:0] MODE_SLAVE = 3'h6;
  localparam logic [2:0] MODE_RESET = 3'h7;
  // Control/status register bits
  localparam int unsigned CMPL_BIT = 7;
  localparam int unsigned MATCH_BIT = 6;
  localparam int unsigned BUSY_BIT = 5;
  localparam int unsigned TXSEL_BIT = 4;
  localparam int unsigned ACKS_BIT = 3;
  localparam int unsigned RW_BIT = 2;
  localparam int unsigned NIC_BIT = 1;
  localparam int unsigned ACKR_BIT = 0;
  localparam logic CMPL_RESET = 1'b1;
  localparam logic ACKR_RESET = 1'b1;
  // Time-out register
  localparam int unsigned TOEN_BIT = 7;
  localparam int unsigned TOF_BIT = 6;
  localparam int unsigned TOCNT_W = 6;
  localparam int unsigned SUB_DIV = 32;
  localparam logic [4:0] SUB_DIV_MAX = 5'h1f;
  // Clock-line debounce in core clocks
  localparam logic [1:0] DEBOUNCE_CYC = 2'h2;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX,
    ST_TX_ACK, ST_IGNORE} tsi_state_type;
endpackage

/* File: core/tsi_i2c_slave.sv */
/*
  Two-wire bus slave with register port, address compare, byte
  transfer through one data register and idle time-out.
  Assumes the bus master supplies clock, START, address and STOP, and
  that the sub clock tick arrives synchronous to core_clk.
*/
// The implementer's own choices: the address-and-strobe port and the address map.
// Function
// - Lines are only pulled low or released, open-drain style.
// - Slave only: transmit and receive, never makes clock, START or STOP.
// - Clock line debounced over two core clocks.
// - Mode field value 110 selects this slave; field resets to 111.
// - Enable low frees the pins and stops the logic.
// - Enable rising keeps control bits, restores status flags.
// - Completion flag low during a byte, set after eight bits; resets one.
// - Address-match flag set on own address, else low.
// - Busy set on START, cleared on STOP.
// - Transmitter select: stored and read back only, direction follows the read/write flag; resets zero.
// - Ack-send bit driven on ninth clock after received byte.
// - Read/write flag one means master reads, zero master writes.
// - No-internal-clock bit allows reception in sleep; no transmit then.
// - Master ack sampled on ninth clock into received-ack flag; resets one.
// - Keep sending while acked; release data line on no ack.
// - All bus data passes through the single data register.
// - No select input; selection by bus address only.
// - Seven-bit own address held in address register bits 7 to 1.
// - First seven bits are address msb first, eighth is read/write.
// - Time-out flag after idle of (count+1)*32 sub clocks when enabled.
`timescale 1ns/1ps
module tsi_i2c_slave (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // System state
  input wire logic sysClockHalted,
  input wire logic subClkTick,
  // Bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Pin ownership and event
  output logic pinsOwned,
  output logic busEvent
);
  logic [1:0] sclSync_ff;
  logic [1:0] sdaSync_ff;
  logic sclDeb_ff;
  logic [1:0] debCnt_ff;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic [2:0] mode_ff;
  logic enable_ff;
  logic enablePrev_ff;
  logic cmpl_ff;
  logic match_ff;
  logic busy_ff;
  logic txSel_ff;
  logic ackSend_ff;
  logic rw_ff;
  logic nic_ff;
  logic ackRecv_ff;
  logic [7:0] data_ff;
  logic [6:0] ownAddr_ff;
  logic toEn_ff;
  logic toFlag_ff;
  logic [5:0] toCnt_ff;
  logic [4:0] subDiv_ff;
  logic [5:0] idleCnt_ff;
  logic [7:0] shift_ff;
  logic [3:0] bitCnt_ff;
  logic sdaDrvLow_ff;
  logic busEvent_ff;
  logic [7:0] regRdData_ff;
  tsi_pkg::tsi_state_type state_ff;
  tsi_pkg::tsi_state_type nxt_state;

  function automatic logic isReg(input logic [2:0] a, input logic [2:0] ofs);
    isReg = (a == ofs);
  endfunction

  wire active = enable_ff && (mode_ff == tsi_pkg::MODE_SLAVE);
  wire sclS = sclSync_ff[1];
  wire sdaS = sdaSync_ff[1];
  wire sclRise = sclDeb_ff && !sclPrev_ff;
  wire sclFall = !sclDeb_ff && sclPrev_ff;
  wire startCond = active && sclDeb_ff && sclPrev_ff && sdaPrev_ff && !sdaS;
  wire stopCond = active && sclDeb_ff && sclPrev_ff && !sdaPrev_ff && sdaS;
  wire wrMode = regWr && isReg(regAddr, tsi_pkg::OFS_MODE);
  wire wrCtrl = regWr && isReg(regAddr, tsi_pkg::OFS_CTRL);
  wire wrData = regWr && isReg(regAddr, tsi_pkg::OFS_DATA);
  wire wrAddr = regWr && isReg(regAddr, tsi_pkg::OFS_ADDR);
  wire wrTout = regWr && isReg(regAddr, tsi_pkg::OFS_TOUT);
  wire enableRise = enable_ff && !enablePrev_ff;
  wire [7:0] shiftIn = {shift_ff[6:0], sdaS};
  wire addrHit = (shiftIn[7:1] == ownAddr_ff);
  // Transmit blocked while the no-internal-clock bit is set and the core clock is halted
  wire txAllowed = !(nic_ff && sysClockHalted);
  wire byteDone = sclRise && (bitCnt_ff == tsi_pkg::BIT_LAST);
  wire ackEdge = sclRise && (bitCnt_ff == tsi_pkg::BIT_ACK);
  wire addrDone = (state_ff == tsi_pkg::ST_ADDR) && byteDone;
  wire rxDone = (state_ff == tsi_pkg::ST_RX) && byteDone;
  wire txDone = (state_ff == tsi_pkg::ST_TX) && byteDone;
  wire txAckSeen = (state_ff == tsi_pkg::ST_TX_ACK) && ackEdge;
  wire subWrap = subClkTick && (subDiv_ff == tsi_pkg::SUB_DIV_MAX);
  wire toExpire = toEn_ff && !busy_ff && subWrap && (idleCnt_ff == toCnt_ff);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
    end
    else
    begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
    end
  end

  // Clock line accepted only after two stable core clocks
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclDeb_ff <= 1'b1;
      debCnt_ff <= 2'h0;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end
    else
    begin
      if (sclS == sclDeb_ff)
        debCnt_ff <= 2'h0;
      else if (debCnt_ff == tsi_pkg::DEBOUNCE_CYC - 2'h1)
      begin
        sclDeb_ff <= sclS;
        debCnt_ff <= 2'h0;
      end
      else
        debCnt_ff <= debCnt_ff + 2'h1;
      sclPrev_ff <= sclDeb_ff;
      sdaPrev_ff <= sdaS;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    if (!active || stopCond)
      nxt_state = tsi_pkg::ST_IDLE;
    else if (startCond)
      nxt_state = tsi_pkg::ST_ADDR;
    else
      unique case (state_ff)
        tsi_pkg::ST_IDLE: nxt_state = tsi_pkg::ST_IDLE;
        tsi_pkg::ST_ADDR:
          if (byteDone)
            nxt_state = addrHit ? tsi_pkg::ST_ADDR_ACK : tsi_pkg::ST_IGNORE;
        tsi_pkg::ST_ADDR_ACK:
          if (ackEdge)
            nxt_state = (rw_ff && txAllowed) ? tsi_pkg::ST_TX : tsi_pkg::ST_RX;
        tsi_pkg::ST_RX:
          if (byteDone)
            nxt_state = tsi_pkg::ST_RX_ACK;
        tsi_pkg::ST_RX_ACK:
          if (ackEdge)
            nxt_state = tsi_pkg::ST_RX;
        tsi_pkg::ST_TX:
          if (byteDone)
            nxt_state = tsi_pkg::ST_TX_ACK;
        tsi_pkg::ST_TX_ACK:
          if (ackEdge)
            nxt_state = sdaS ? tsi_pkg::ST_IGNORE : tsi_pkg::ST_TX;
        tsi_pkg::ST_IGNORE: nxt_state = tsi_pkg::ST_IGNORE;
      endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= tsi_pkg::ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (startCond || ackEdge)
        bitCnt_ff <= 4'h0;
      else if (sclRise)
        bitCnt_ff <= bitCnt_ff + 4'h1;
      if (nxt_state == tsi_pkg::ST_TX && state_ff != tsi_pkg::ST_TX)
        shift_ff <= data_ff;
      else if (sclFall && state_ff == tsi_pkg::ST_TX)
        shift_ff <= {shift_ff[6:0], 1'b0};
      else if (sclRise && (state_ff == tsi_pkg::ST_ADDR || state_ff == tsi_pkg::ST_RX))
        shift_ff <= shiftIn;
    end
  end

  // Data line pull-down, updated on clock falls; released on START, STOP or when inactive
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sdaDrvLow_ff <= 1'b0;
    else if (!active || stopCond || startCond)
      sdaDrvLow_ff <= 1'b0;
    else if (sclFall)
      unique case (state_ff)
        tsi_pkg::ST_ADDR_ACK: sdaDrvLow_ff <= (bitCnt_ff == tsi_pkg::BIT_ACK) ? 1'b1 :
          (rw_ff && txAllowed && !data_ff[7]);
        tsi_pkg::ST_RX_ACK: sdaDrvLow_ff <= (bitCnt_ff == tsi_pkg::BIT_ACK) ?
          !ackSend_ff : 1'b0;
        tsi_pkg::ST_TX: sdaDrvLow_ff <= !shift_ff[7];
        tsi_pkg::ST_TX_ACK: sdaDrvLow_ff <= 1'b0;
        default: sdaDrvLow_ff <= 1'b0;
      endcase
  end

  // Address ack goes out on the fall ending the eighth bit
  // Status flags; enable rising wins over bus events
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmpl_ff <= tsi_pkg::CMPL_RESET;
      match_ff <= 1'b0;
      busy_ff <= 1'b0;
      rw_ff <= 1'b0;
      ackRecv_ff <= tsi_pkg::ACKR_RESET;
      busEvent_ff <= 1'b0;
    end
    else
    begin
      busEvent_ff <= addrDone || rxDone || txDone;
      if (enableRise)
      begin
        cmpl_ff <= tsi_pkg::CMPL_RESET;
        match_ff <= 1'b0;
        busy_ff <= 1'b0;
        rw_ff <= 1'b0;
        ackRecv_ff <= tsi_pkg::ACKR_RESET;
      end
      else
      begin
        if (startCond)
          busy_ff <= 1'b1;
        else if (stopCond)
          busy_ff <= 1'b0;
        if (addrDone || rxDone || txDone)
          cmpl_ff <= 1'b1;
        else if (startCond || (sclFall && bitCnt_ff == 4'h0 &&
          (state_ff == tsi_pkg::ST_RX || state_ff == tsi_pkg::ST_TX)))
          cmpl_ff <= 1'b0;
        if (addrDone)
        begin
          match_ff <= addrHit;
          rw_ff <= addrHit ? sdaS : rw_ff;
        end
        else if (startCond)
          match_ff <= 1'b0;
        if (txAckSeen)
          ackRecv_ff <= sdaS;
      end
    end
  end

  // Software registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= tsi_pkg::MODE_RESET;
      enable_ff <= 1'b0;
      enablePrev_ff <= 1'b0;
      txSel_ff <= 1'b0;
      ackSend_ff <= 1'b0;
      nic_ff <= 1'b0;
      ownAddr_ff <= 7'h00;
      toEn_ff <= 1'b0;
      toCnt_ff <= 6'h00;
    end
    else
    begin
      enablePrev_ff <= enable_ff;
      if (wrMode)
      begin
        mode_ff <= regWrData[tsi_pkg::MODE_LSB +: 3];
        enable_ff <= regWrData[tsi_pkg::ENABLE_BIT];
      end
      if (wrCtrl)
      begin
        txSel_ff <= regWrData[tsi_pkg::TXSEL_BIT];
        ackSend_ff <= regWrData[tsi_pkg::ACKS_BIT];
        nic_ff <= regWrData[tsi_pkg::NIC_BIT];
      end
      if (wrAddr)
        ownAddr_ff <= regWrData[7:1];
      if (wrTout)
      begin
        toEn_ff <= regWrData[tsi_pkg::TOEN_BIT];
        toCnt_ff <= regWrData[tsi_pkg::TOCNT_W-1:0];
      end
    end
  end

  // Data register: software byte or received byte
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      data_ff <= 8'h00;
    else if (rxDone)
      data_ff <= shiftIn;
    else if (wrData)
      data_ff <= regWrData;
  end

  // Idle time-out counted in sub clock ticks divided by 32
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      subDiv_ff <= 5'h00;
      idleCnt_ff <= 6'h00;
      toFlag_ff <= 1'b0;
    end
    else
    begin
      if (busy_ff || !toEn_ff || !active)
      begin
        subDiv_ff <= 5'h00;
        idleCnt_ff <= 6'h00;
      end
      else if (subClkTick)
      begin
        subDiv_ff <= subDiv_ff + 5'h01;
        if (subWrap && idleCnt_ff != toCnt_ff)
          idleCnt_ff <= idleCnt_ff + 6'h01;
      end
      if (toExpire)
        toFlag_ff <= 1'b1;
      else if (wrTout && !regWrData[tsi_pkg::TOF_BIT])
        toFlag_ff <= 1'b0;
    end
  end

  wire [7:0] modeRd = {mode_ff, 3'h0, enable_ff, 1'b0};
  wire [7:0] ctrlRd = {cmpl_ff, match_ff, busy_ff, txSel_ff, ackSend_ff, rw_ff, nic_ff,
    ackRecv_ff};
  wire [7:0] toutRd = {toEn_ff, toFlag_ff, toCnt_ff};
  wire [7:0] rdMux = isReg(regAddr, tsi_pkg::OFS_MODE) ? modeRd :
    isReg(regAddr, tsi_pkg::OFS_CTRL) ? ctrlRd :
    isReg(regAddr, tsi_pkg::OFS_DATA) ? data_ff :
    isReg(regAddr, tsi_pkg::OFS_ADDR) ? {ownAddr_ff, 1'b0} :
    isReg(regAddr, tsi_pkg::OFS_TOUT) ? toutRd : 8'h00;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      regRdData_ff <= 8'h00;
    else if (regRd)
      regRdData_ff <= rdMux;
    else
      regRdData_ff <= 8'h00;
  end

  assign regRdData = regRdData_ff;
  assign sclOut = 1'b0;
  assign sclOe = 1'b0;
  assign sdaOut = 1'b0;
  assign sdaOe = sdaDrvLow_ff && active;
  assign pinsOwned = active;
  assign busEvent = busEvent_ff;

  property p_busy_start;
    @(posedge core_clk) disable iff (rst) startCond && !enableRise |=> busy_ff;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set on start");

  property p_busy_stop;
    @(posedge core_clk) disable iff (rst) stopCond && !enableRise |=> !busy_ff;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("busy not cleared on stop");

  property p_cmpl_byte;
    @(posedge core_clk) disable iff (rst) (rxDone || txDone) && !enableRise
      |=> cmpl_ff && busEvent;
  endproperty
  a_cmpl_byte: assert property (p_cmpl_byte) else $error("byte end not flagged");

  property p_match;
    @(posedge core_clk) disable iff (rst) addrDone && !enableRise |=> match_ff == $past(addrHit);
  endproperty
  a_match: assert property (p_match) else $error("address match flag wrong");

  property p_scl_never;
    @(posedge core_clk) disable iff (rst) !sclOe;
  endproperty
  a_scl_never: assert property (p_scl_never) else $error("clock line driven");

  property p_sda_low_only;
    @(posedge core_clk) disable iff (rst) sdaOe |-> !sdaOut;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("data line driven high");

  property p_enable_rise;
    @(posedge core_clk) disable iff (rst) enableRise |=> cmpl_ff && ackRecv_ff && !busy_ff
      && !match_ff && !rw_ff;
  endproperty
  a_enable_rise: assert property (p_enable_rise) else $error("flags not restored");

  property p_disabled_free;
    @(posedge core_clk) disable iff (rst) !active |-> !sdaOe && !pinsOwned;
  endproperty
  a_disabled_free: assert property (p_disabled_free) else $error("pins held when off");

  property p_ackr;
    @(posedge core_clk) disable iff (rst) txAckSeen && !enableRise |=> ackRecv_ff == $past(sdaS);
  endproperty
  a_ackr: assert property (p_ackr) else $error("received ack not stored");

  property p_nack_release;
    @(posedge core_clk) disable iff (rst) txAckSeen && sdaS |=> ##[0:3] !sdaOe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("data line held on nack");
endmodule

/* File: tb/tsi_bus_master.sv */
/*
  Behavioural two-wire bus master: START, bytes out and in, STOP.
  Assumes pull-ups on both lines, resolved by the instantiating bench.
*/
`timescale 1ns/1ps
module tsi_bus_master (
  // Resolved line levels
  input wire logic sclLine,
  input wire logic sdaLine,
  // Open-drain pulls, high pulls the line low
  output logic sclPull,
  output logic sdaPull
);
  // Clock line stands released between frames, 80 ns bit period
  initial
  begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end

  task automatic start();
    sdaPull = 1'b1;
    #40;
    sclPull = 1'b1;
  endtask

  task automatic stop();
    #20;
    sdaPull = 1'b1;
    #20;
    sclPull = 1'b0;
    #40;
    sdaPull = 1'b0;
    #40;
  endtask

  // A short low glitch inside the high phase must be filtered
  task automatic bitOut(input logic b, input logic glitch);
    #20;
    sdaPull = ~b;
    #20;
    sclPull = 1'b0;
    if (glitch)
    begin
      #15;
      sclPull = 1'b1;
      #8;
      sclPull = 1'b0;
      #17;
    end
    else
      #40;
    sclPull = 1'b1;
  endtask

  task automatic bitIn(output logic b);
    #20;
    sdaPull = 1'b0;
    #20;
    sclPull = 1'b0;
    #20;
    b = sdaLine;
    #20;
    sclPull = 1'b1;
  endtask

  task automatic sendByte(input logic [7:0] d, input int g, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitOut(d[i], i == g);
    bitIn(ack);
  endtask

  task automatic recvByte(input logic ackVal, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bitIn(d[i]);
    bitOut(ackVal, 1'b0);
  endtask
endmodule

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the two-wire slave: register port tasks, bus
  master model, read results compared from a queue one cycle later.
  Assumes the register offsets and bit positions of the package.
*/
`timescale 1ns/1ps
module tb_top;
  logic core_clk;
  logic rst;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic sysClockHalted;
  logic subClkTick;
  logic sclOut, sclOe, sdaOut, sdaOe, pinsOwned, busEvent;
  logic mScl, mSda;
  wire sclLine;
  wire sdaLine;
  logic [1:0] tickCnt;
  logic rdPend;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  string nameQ[$];
  logic [7:0] monM, monE;
  int miscompares;
  int check_count;
  int cycles;
  logic [31:0] rnd;
  logic [6:0] own;
  logic [7:0] d1, d2, got;
  logic ack;

  assign sclLine = ~(mScl | (sclOe & ~sclOut));
  assign sdaLine = ~(mSda | (sdaOe & ~sdaOut));

  tsi_i2c_slave dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sysClockHalted(sysClockHalted), .subClkTick(subClkTick), .sclIn(sclLine),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .pinsOwned(pinsOwned), .busEvent(busEvent));

  tsi_bus_master master (.sclLine(sclLine), .sdaLine(sdaLine), .sclPull(mScl),
    .sdaPull(mSda));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic endTest(input string t);
    check("sclOe", {7'h00, sclOe}, 8'h00);
    check("sclOut", {7'h00, sclOut}, 8'h00);
    check("sdaOut", {7'h00, sdaOut}, 8'h00);
    $display("test %s done", t);
  endtask

  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
    input string n);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    mskQ.push_back(m);
    nameQ.push_back(n);
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask

  task automatic waitEvent();
    int n;
    n = 0;
    @(negedge core_clk);
    while (busEvent !== 1'b1 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 300)
      check("busEvent", 8'h00, 8'h01);
  endtask

  // Sub-clock tick every fourth core cycle; read data compared a cycle later
  always @(posedge core_clk)
  begin
    tickCnt <= tickCnt + 2'h1;
    subClkTick <= (tickCnt == 2'h3);
    rdPend <= regRd;
    cycles = cycles + 1;
    if (rdPend === 1'b1)
    begin
      monM = mskQ.pop_front();
      monE = expQ.pop_front();
      check(nameQ.pop_front(), regRdData & monM, monE & monM);
    end
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    rst = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    sysClockHalted = 1'b0;
    subClkTick = 1'b0;
    tickCnt = 2'h0;
    rdPend = 1'b0;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    rnd = 32'hb08677cb;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    regRead(tsi_pkg::OFS_MODE, 8'he0, 8'hff, "mode");
    regRead(tsi_pkg::OFS_CTRL, 8'h81, 8'hff, "ctrl");
    regRead(tsi_pkg::OFS_ADDR, 8'h00, 8'hff, "addr");
    regRead(tsi_pkg::OFS_TOUT, 8'h00, 8'hff, "tout");
    regRead(3'h5, 8'h00, 8'hff, "unmapped");
    check("pinsOwned", {7'h00, pinsOwned}, 8'h00);
    endTest("reset");
    own = rnd[6:0];
    regWrite(tsi_pkg::OFS_ADDR, {own, 1'b0});
    regRead(tsi_pkg::OFS_ADDR, {own, 1'b0}, 8'hff, "addr");
    #3;
    master.start();
    master.sendByte({own, 1'b0}, 8, ack);
    check("ackDisabled", {7'h00, ack}, 8'h01);
    master.stop();
    endTest("disabled");
    for (int m = 0; m < 8; m++)
    begin
      regWrite(tsi_pkg::OFS_MODE, {m[2:0], 5'h02});
      repeat (2) @(negedge core_clk);
      check("pinsOwned", {7'h00, pinsOwned}, {7'h00, m == 6});
    end
    regWrite(tsi_pkg::OFS_MODE, 8'hc2);
    regRead(tsi_pkg::OFS_MODE, 8'hc2, 8'hff, "mode");
    endTest("modes");
    rnd = lfsrNext(rnd);
    d1 = rnd[7:0];
    d2 = rnd[15:8];
    regWrite(tsi_pkg::OFS_CTRL, 8'h02);
    sysClockHalted <= 1'b1;
    #3;
    master.start();
    master.sendByte({own, 1'b0}, 8, ack);
    check("ackAddr", {7'h00, ack}, 8'h00);
    regRead(tsi_pkg::OFS_CTRL, 8'h60, 8'h64, "ctrlWrite");
    #3;
    master.sendByte(d1, 3, ack);
    check("ackData", {7'h00, ack}, 8'h00);
    regRead(tsi_pkg::OFS_DATA, d1, 8'hff, "rxByte1");
    regRead(tsi_pkg::OFS_CTRL, 8'h80, 8'h80, "complete");
    regWrite(tsi_pkg::OFS_CTRL, 8'h0a);
    #3;
    master.sendByte(d2, 8, ack);
    check("ackWithheld", {7'h00, ack}, 8'h01);
    regRead(tsi_pkg::OFS_DATA, d2, 8'hff, "rxByte2");
    regWrite(tsi_pkg::OFS_CTRL, 8'h02);
    #3;
    master.stop();
    regRead(tsi_pkg::OFS_CTRL, 8'h00, 8'h20, "busyStop");
    sysClockHalted <= 1'b0;
    endTest("receive");
    #3;
    master.start();
    master.sendByte({own ^ 7'h01, 1'b0}, 8, ack);
    check("ackOther", {7'h00, ack}, 8'h01);
    regRead(tsi_pkg::OFS_CTRL, 8'h00, 8'h40, "noMatch");
    #3;
    master.stop();
    endTest("foreign");
    rnd = lfsrNext(rnd);
    d1 = rnd[7:0];
    d2 = rnd[15:8];
    regWrite(tsi_pkg::OFS_DATA, d1);
    #3;
    master.start();
    master.sendByte({own, 1'b1}, 8, ack);
    check("ackRead", {7'h00, ack}, 8'h00);
    regRead(tsi_pkg::OFS_CTRL, 8'h44, 8'h44, "ctrlRead");
    fork
      begin
        #3;
        master.recvByte(1'b0, got);
      end
      begin
        waitEvent();
        regWrite(tsi_pkg::OFS_DATA, d2);
      end
    join
    check("txByte1", got, d1);
    regRead(tsi_pkg::OFS_CTRL, 8'h00, 8'h01, "ackRecv");
    #3;
    master.recvByte(1'b1, got);
    #10;
    check("sdaFree", {7'h00, sdaLine}, 8'h01);
    check("txByte2", got, d2);
    regRead(tsi_pkg::OFS_CTRL, 8'h01, 8'h01, "nackRecv");
    #3;
    master.stop();
    regRead(tsi_pkg::OFS_CTRL, 8'h00, 8'h20, "busyStop");
    endTest("transmit");
    #3;
    master.start();
    master.sendByte({own, 1'b0}, 8, ack);
    regWrite(tsi_pkg::OFS_CTRL, 8'h18);
    regWrite(tsi_pkg::OFS_MODE, 8'hc0);
    regWrite(tsi_pkg::OFS_MODE, 8'hc2);
    regRead(tsi_pkg::OFS_CTRL, 8'h99, 8'hff, "reEnable");
    regWrite(tsi_pkg::OFS_CTRL, 8'h00);
    #3;
    master.stop();
    endTest("reenable");
    // Count 1 expires after 64 ticks, 256 core cycles
    regWrite(tsi_pkg::OFS_TOUT, 8'h81);
    repeat (240) @(posedge core_clk);
    regRead(tsi_pkg::OFS_TOUT, 8'h81, 8'hff, "toutEarly");
    repeat (40) @(posedge core_clk);
    regRead(tsi_pkg::OFS_TOUT, 8'hc1, 8'hff, "toutSet");
    regWrite(tsi_pkg::OFS_TOUT, 8'h01);
    regRead(tsi_pkg::OFS_TOUT, 8'h01, 8'hff, "toutClear");
    endTest("timeout");
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule
